// >>> axd_aux_io.sv
`timescale 1ns/1ps
`include "axd_cfg.svh"
module axd_aux_io #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    soft_rst_i,
  // Register port, one byte per access
  input  wire logic [`AXD_ADDR_W-1:0]  reg_addr_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_rd_i,
  output logic [7:0]                   reg_rdata_o,
  // Conversion engine
  input  wire logic                    cycle_done_i,
  input  wire logic [CNT_W-1:0]        dr_hold_cycles_i,
  input  wire logic [11:0]             adc_raw_i,
  output logic [11:0]                  adc_code_o,
  // Alarm control source
  input  wire logic [1:0]              alarm_claim_i,
  input  wire logic [1:0]              alarm_level_i,
  // Analog side
  output logic                         self_check_o,
  output logic [11:0]                  dac_code_o,
  // Pins: index 0 is line zero, index 1 is line one
  input  wire logic [1:0]              pin_line_i,
  output logic [1:0]                   pin_line_o,
  output logic [1:0]                   pin_line_oe_o
);
  import axd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    axd_word_t  aux_output_code;
    axd_word_t  pin_io_control;
    axd_word_t  misc_function_control;
    logic [11:0] dac_out;
    logic [11:0] adc_code;
    logic [1:0]  in_s1;
    logic [1:0]  in_s2;
    logic [7:0]  rdata;
  } axd_state_t;
  axd_state_t st_q, st_d;

  logic       dr_active;
  logic       dr_level;
  logic [1:0] misc_claim;
  axd_word_t  rd_word;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = `AXD_RST_WORD;
    case (reg_addr_i)
      `AXD_OFF_AUX_CODE_LO,
      `AXD_OFF_AUX_CODE_HI: rd_word = st_q.aux_output_code;
      `AXD_OFF_PIN_CTRL_LO,
      `AXD_OFF_PIN_CTRL_HI: rd_word = st_q.pin_io_control;
      `AXD_OFF_MISC_LO,
      `AXD_OFF_MISC_HI:     rd_word = st_q.misc_function_control;
      default:              rd_word = `AXD_RST_WORD;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.in_s1 = pin_line_i;
    st_d.in_s2 = st_q.in_s1;
    if (cycle_done_i) begin
      st_d.adc_code = adc_raw_i;
    end
    if (reg_rd_i) begin
      st_d.rdata = reg_addr_i[0] ? rd_word[15:8] : rd_word[7:0];
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        `AXD_OFF_AUX_CODE_LO: st_d.aux_output_code[7:0] = reg_wdata_i;
        `AXD_OFF_AUX_CODE_HI: st_d.aux_output_code[15:8] = reg_wdata_i;
        `AXD_OFF_PIN_CTRL_LO: st_d.pin_io_control[7:0] = reg_wdata_i;
        `AXD_OFF_PIN_CTRL_HI: st_d.pin_io_control[15:8] = reg_wdata_i;
        `AXD_OFF_MISC_LO: st_d.misc_function_control[7:0] = reg_wdata_i;
        `AXD_OFF_MISC_HI: st_d.misc_function_control[15:8] = reg_wdata_i;
        `AXD_OFF_CMD_LO: begin
          if (reg_wdata_i[`AXD_CMD_DAC_LATCH]) begin
            st_d.dac_out = st_q.aux_output_code[11:0];
          end
        end
        default: st_d.rdata = st_d.rdata;
      endcase
    end
    st_d.aux_output_code       = st_d.aux_output_code & `AXD_CODE_MASK;
    st_d.pin_io_control        = st_d.pin_io_control & `AXD_PIN_MASK;
    st_d.misc_function_control =
      st_d.misc_function_control & `AXD_MISC_MASK;
    if (soft_rst_i) begin
      st_d.aux_output_code = `AXD_RST_WORD;
      st_d.pin_io_control  = `AXD_RST_WORD;
      st_d.misc_function_control[`AXD_MISC_SELF_CHECK] = 1'b0;
      st_d.dac_out = st_d.aux_output_code[11:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Data-ready pulse and pin muxing
  // ----------------------------------------------------------------
  axd_pulse_gen #(
    .CNT_W         (CNT_W)
  ) u_pulse (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .cycle_done_i  (cycle_done_i),
    .hold_cycles_i (dr_hold_cycles_i),
    .active_o      (dr_active)
  );

  // Polarity bit set gives active high
  assign dr_level = ~(dr_active ^
    st_q.misc_function_control[`AXD_MISC_DR_POL]);

  assign misc_claim[0] = st_q.misc_function_control[`AXD_MISC_DR_EN] &
    ~st_q.misc_function_control[`AXD_MISC_DR_SEL];
  assign misc_claim[1] = st_q.misc_function_control[`AXD_MISC_DR_EN] &
    st_q.misc_function_control[`AXD_MISC_DR_SEL];

  axd_pin_mux u_mux0 (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .misc_claim_i  (misc_claim[0]),
    .misc_level_i  (dr_level),
    .alarm_claim_i (alarm_claim_i[0]),
    .alarm_level_i (alarm_level_i[0]),
    .pin_dir_i     (st_q.pin_io_control[`AXD_PIN_DIR_ZERO]),
    .pin_level_i   (st_q.pin_io_control[`AXD_PIN_LVL_ZERO]),
    .pad_o         (pin_line_o[0]),
    .pad_oe_o      (pin_line_oe_o[0])
  );

  axd_pin_mux u_mux1 (
    .clk_i         (clk_i),
    .sys_rst_i     (sys_rst_i),
    .misc_claim_i  (misc_claim[1]),
    .misc_level_i  (dr_level),
    .alarm_claim_i (alarm_claim_i[1]),
    .alarm_level_i (alarm_level_i[1]),
    .pin_dir_i     (st_q.pin_io_control[`AXD_PIN_DIR_ONE]),
    .pin_level_i   (st_q.pin_io_control[`AXD_PIN_LVL_ONE]),
    .pad_o         (pin_line_o[1]),
    .pad_oe_o      (pin_line_oe_o[1])
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign self_check_o =
    st_q.misc_function_control[`AXD_MISC_SELF_CHECK];
  assign dac_code_o  = st_q.dac_out;
  assign adc_code_o  = st_q.adc_code;
  assign reg_rdata_o = st_q.rdata;
endmodule

// >>> axd_aux_io_properties.sv
`timescale 1ns/1ps
module axd_aux_io_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        soft_rst_i,
  // Register port
  input wire logic [5:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  // Converter and outputs
  input wire logic        cycle_done_i,
  input wire logic [11:0] adc_raw_i,
  input wire logic [11:0] adc_code_o,
  input wire logic        self_check_o,
  input wire logic [11:0] dac_code_o,
  input wire logic [1:0]  pin_line_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic latch_w;
  assign latch_w = reg_wr_i && reg_addr_i == 6'h3e && reg_wdata_i[2];
  sequence s_cleared;
    dac_code_o == 12'h000 && !self_check_o;
  endsequence
  sequence s_read(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  property p_rst_vals;
    $fell(sys_rst_i) |-> s_cleared ##0 pin_line_oe_o == 2'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("state after reset wrong");
  property p_dac_hold;
    !latch_w && !soft_rst_i |=> $stable(dac_code_o);
  endproperty
  a_dac_hold: assert property (p_dac_hold)
    else $error("dac output moved without latch");
  property p_soft_clear;
    soft_rst_i |=> s_cleared;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("soft reset did not clear");
  property p_st_set;
    reg_wr_i && reg_addr_i == 6'h35 && !soft_rst_i
      |=> self_check_o == $past(reg_wdata_i[0]);
  endproperty
  a_st_set: assert property (p_st_set)
    else $error("self check bit wrong");
  property p_adc_cap;
    cycle_done_i |=> adc_code_o == $past(adc_raw_i);
  endproperty
  a_adc_cap: assert property (p_adc_cap)
    else $error("converter code not captured");
  property p_adc_hold;
    !cycle_done_i |=> $stable(adc_code_o);
  endproperty
  a_adc_hold: assert property (p_adc_hold)
    else $error("converter code moved");
  property p_unmapped;
    reg_rd_i && reg_addr_i < 6'h30 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_cmd_rd;
    s_read(6'h3e) or s_read(6'h3f) |=> reg_rdata_o == 8'h00;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd)
    else $error("command byte readable");
  property p_code_hi;
    s_read(6'h31) |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_code_hi: assert property (p_code_hi)
    else $error("unused code bits set");
endmodule
bind axd_aux_io axd_aux_io_properties i_axd_aux_io_properties (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cycle_done_i(cycle_done_i),
  .adc_raw_i(adc_raw_i), .adc_code_o(adc_code_o),
  .self_check_o(self_check_o), .dac_code_o(dac_code_o),
  .pin_line_oe_o(pin_line_oe_o)
);

// >>> axd_cfg.svh
`ifndef AXD_CFG_SVH
`define AXD_CFG_SVH
`define AXD_ADDR_W            6
`define AXD_OFF_AUX_CODE_LO   6'h30
`define AXD_OFF_AUX_CODE_HI   6'h31
`define AXD_OFF_PIN_CTRL_LO   6'h32
`define AXD_OFF_PIN_CTRL_HI   6'h33
`define AXD_OFF_MISC_LO       6'h34
`define AXD_OFF_MISC_HI       6'h35
`define AXD_OFF_CMD_LO        6'h3e
`define AXD_OFF_CMD_HI        6'h3f
`define AXD_CMD_DAC_LATCH     2
`define AXD_MISC_SELF_CHECK   8
`define AXD_MISC_DR_EN        2
`define AXD_MISC_DR_POL       1
`define AXD_MISC_DR_SEL       0
`define AXD_PIN_DIR_ZERO      9
`define AXD_PIN_DIR_ONE       8
`define AXD_PIN_LVL_ZERO      1
`define AXD_PIN_LVL_ONE       0
`define AXD_MISC_MASK         16'h0107
`define AXD_PIN_MASK          16'h0303
`define AXD_CODE_MASK         16'h0fff
`define AXD_RST_WORD          16'h0000
`define AXD_DR_LOW_DEFAULT    12'h004
`endif

// >>> axd_host.sv
`timescale 1ns/1ps
module axd_host (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic [5:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 6'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // Released data bus shows the inverse, never the last value
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    @(posedge clk_i);
    #1 d = reg_rdata_i;
  endtask
endmodule

// >>> axd_pin_mux.sv
`timescale 1ns/1ps
`include "axd_cfg.svh"
module axd_pin_mux (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Miscellaneous source
  input  wire logic misc_claim_i,
  input  wire logic misc_level_i,
  // Alarm source
  input  wire logic alarm_claim_i,
  input  wire logic alarm_level_i,
  // Pin control source
  input  wire logic pin_dir_i,
  input  wire logic pin_level_i,
  // Pad
  output logic      pad_o,
  output logic      pad_oe_o
);
  import axd_pkg::*;
  typedef struct packed {
    logic pad;
    logic oe;
  } axd_mux_state_t;
  axd_mux_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (misc_claim_i) begin
      st_d.pad = misc_level_i;
      st_d.oe  = 1'b1;
    end else if (alarm_claim_i) begin
      st_d.pad = alarm_level_i;
      st_d.oe  = 1'b1;
    end else begin
      st_d.oe  = pin_dir_i;
      st_d.pad = pin_dir_i & pin_level_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pad_o    = st_q.pad;
  assign pad_oe_o = st_q.oe;
endmodule

// >>> axd_pkg.sv
package axd_pkg;
  typedef logic [15:0] axd_word_t;
  typedef enum logic [1:0] {
    AXD_SRC_PIN,
    AXD_SRC_ALARM,
    AXD_SRC_MISC
  } axd_src_t;
endpackage

// >>> axd_pulse_gen.sv
`timescale 1ns/1ps
`include "axd_cfg.svh"
module axd_pulse_gen #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Control
  input  wire logic             cycle_done_i,
  input  wire logic [CNT_W-1:0] hold_cycles_i,
  // Pulse
  output logic                  active_o
);
  import axd_pkg::*;
  typedef struct packed {
    logic             active;
    logic [CNT_W-1:0] cnt;
  } axd_pg_state_t;
  axd_pg_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (cycle_done_i) begin
      st_d.active = 1'b1;
      st_d.cnt    = hold_cycles_i;
    end else if (st_q.active) begin
      if (st_q.cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
        st_d.active = 1'b0;
        st_d.cnt    = '0;
      end else begin
        st_d.cnt = st_q.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active_o = st_q.active;
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import axd_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic cycle_done_i = 1'b0;
  logic [11:0] dr_hold_cycles_i = 12'h000;
  logic [11:0] adc_raw_i = 12'h000;
  logic [1:0] alarm_claim_i = 2'h0;
  logic [1:0] alarm_level_i = 2'h0;
  logic [5:0] reg_addr_i, a6;
  logic reg_wr_i, reg_rd_i, pol, sel;
  logic [7:0] reg_wdata_i, reg_rdata_o, r, d;
  logic [11:0] adc_code_o, dac_code_o, prev, raw;
  logic self_check_o;
  logic [1:0] pin_line_o, pin_line_oe_o, pin_line_i;
  axd_word_t v;
  int failures = 0;
  int checks = 0;
  int n;
  always #5 clk_i = ~clk_i;
  // Pull-ups: an undriven line reads high
  assign pin_line_i = (pin_line_o & pin_line_oe_o) | ~pin_line_oe_o;
  axd_aux_io i_axd_aux_io (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cycle_done_i(cycle_done_i),
    .dr_hold_cycles_i(dr_hold_cycles_i), .adc_raw_i(adc_raw_i),
    .adc_code_o(adc_code_o), .alarm_claim_i(alarm_claim_i),
    .alarm_level_i(alarm_level_i), .self_check_o(self_check_o),
    .dac_code_o(dac_code_o), .pin_line_i(pin_line_i),
    .pin_line_o(pin_line_o), .pin_line_oe_o(pin_line_oe_o));
  axd_host i_axd_host (.clk_i(clk_i), .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [7:0] mask(input logic [5:0] a);
    case (a)
      6'h30: return 8'hff;
      6'h31: return 8'h0f;
      6'h32, 6'h33: return 8'h03;
      6'h34: return 8'h07;
      6'h35: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [1:0] swap(input logic [1:0] x);
    return {x[0], x[1]};
  endfunction
  task automatic pulse(input int h);
    @(posedge clk_i);
    raw = 12'($urandom);
    adc_raw_i <= raw;
    dr_hold_cycles_i <= h[11:0];
    cycle_done_i <= 1'b1;
    @(posedge clk_i);
    cycle_done_i <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge clk_i);
      #1;
      n += int'(pin_line_oe_o[sel] && pin_line_o[sel] == pol);
    end
    chk(16'(n), 16'((h < 2) ? 1 : h));
    chk(pin_line_o[~sel], !pol);
    chk(adc_code_o, raw);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(39));
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 'h30; a < 'h36; a++) begin
      i_axd_host.rd(6'(a), r);
      chk(r, 8'h00);
    end
    chk(pin_line_oe_o, 2'h0);
    repeat (40) begin
      a6 = 6'h2e + 6'($urandom_range(17));
      d = 8'($urandom);
      i_axd_host.wr(a6, d);
      i_axd_host.rd(a6, r);
      chk(r, d & mask(a6));
    end
    i_axd_host.wr(6'h30, 8'h00);
    i_axd_host.wr(6'h31, 8'h00);
    i_axd_host.wr(6'h3e, 8'h04);
    prev = 12'h000;
    repeat (5) begin
      v = 16'($urandom);
      i_axd_host.wr(6'h30, v[7:0]);
      i_axd_host.wr(6'h31, v[15:8]);
      i_axd_host.wr(6'h3e, 8'($urandom) & 8'hfb);
      step(1);
      chk(dac_code_o, prev);
      i_axd_host.wr(6'h3e, 8'h04);
      step(1);
      chk(dac_code_o, v[11:0]);
      prev = v[11:0];
    end
    i_axd_host.wr(6'h34, 8'h00);
    for (int k = 0; k < 16; k++) begin
      i_axd_host.wr(6'h32, 8'(k[1:0]));
      i_axd_host.wr(6'h33, 8'(k[3:2]));
      step(2);
      chk(pin_line_oe_o, swap(k[3:2]));
      chk(pin_line_o & pin_line_oe_o, swap(k[1:0] & k[3:2]));
    end
    for (int m = 0; m < 4; m++) begin
      pol = m[1];
      sel = m[0];
      @(posedge clk_i);
      alarm_claim_i <= 2'h3;
      alarm_level_i <= {2{~pol}};
      i_axd_host.wr(6'h32, {6'h00, pol, pol});
      i_axd_host.wr(6'h34, {5'h00, 1'b1, pol, sel});
      pulse(m);
      pulse(2 + $urandom_range(7));
    end
    i_axd_host.wr(6'h35, 8'h01);
    step(1);
    chk(self_check_o, 1'b1);
    i_axd_host.wr(6'h34, 8'h05);
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    step(2);
    chk(self_check_o, 1'b0);
    i_axd_host.rd(6'h34, r);
    chk(r, 8'h05);
    i_axd_host.rd(6'h33, r);
    chk(r, 8'h00);
    tally_and_finish();
  end
endmodule
